//--- hdl/adc_bank_defines.svh
// Register offsets, reset values, field positions and timing counts
// Assumes inclusion by the converter register bank and its helpers
`ifndef ADC_BANK_DEFINES_SVH
`define ADC_BANK_DEFINES_SVH

`define ADDR_PART_CODE     5'h00
`define ADDR_MAIN_CFG      5'h01
`define ADDR_INPUT_CFG     5'h02
`define ADDR_CORNER_LOW    5'h03
`define ADDR_CORNER_HIGH   5'h04
`define ADDR_OFFSET_LOW    5'h05
`define ADDR_OFFSET_MID    5'h06
`define ADDR_OFFSET_HIGH   5'h07
`define ADDR_GAIN_LOW      5'h08
`define ADDR_GAIN_MID      5'h09
`define ADDR_GAIN_HIGH     5'h0A

`define RST_MAIN_CFG       8'h52
`define RST_INPUT_CFG      8'h08
`define RST_CORNER_LOW     8'h32
`define RST_CORNER_HIGH    8'h03
`define RST_OFFSET_BYTE    8'h00
`define RST_GAIN_LOW       8'h00
`define RST_GAIN_MID       8'h00
`define RST_GAIN_HIGH      8'h40

`define OPCODE_READ        3'h1
`define OPCODE_WRITE       3'h2
`define OPCODE_COUNT       3'h0

`define SYNC_BIT           7
`define MODE_BIT           6
`define RATE_HI            5
`define RATE_LO            3
`define PHASE_BIT          2
`define FILT_HI            1
`define FILT_LO            0
`define RSVD_BIT           7
`define ROUTE_HI           6
`define ROUTE_LO           4
`define AMP_CHOPPING_ENABLE_BIT           3
`define GAIN_HI            2
`define GAIN_LO            0

`define DISCARD_RESULTS    6'h3F
`define BYTE_GAP_CYCLES    24
`define UNITY_SHIFT        22
`define CAL_BYPASS_MIN     2'h2

`endif

//--- hdl/adc_bank_pkg.sv
// Types shared by the converter register bank and its helpers
// Assumes the defines header is compiled alongside
package adc_bank_pkg;

  typedef enum logic [1:0] {
    ST_OPCODE,
    ST_COUNT,
    ST_READ,
    ST_WRITE
  } cmd_state_e;

  typedef struct packed {
    cmd_state_e        state;
    logic              is_write;
    logic [4:0]        addr;
    logic [4:0]        remain;
    logic [10:1][7:0]  regs;
    logic [7:0]        rd_data;
    logic              rd_valid;
    logic              restart;
  } bank_s;

  typedef struct packed {
    logic [5:0] left;
    logic       active;
  } discard_s;

  typedef struct packed {
    logic [31:0] data;
    logic        valid;
  } scale_s;

endpackage

//--- hdl/discard_counter.sv
// Counts conversion results lost after a conversion path restart
// Assumes restart and result strobes are single-cycle pulses on mclk
`timescale 1ns/1ps
`include "adc_bank_defines.svh"

module discard_counter
  import adc_bank_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       restart,
  input  wire logic       result_strobe,
  output logic [5:0]      discard_left,
  output logic            discard_active
);

  discard_s st_reg;
  discard_s st_next;

  always_comb
  begin
    st_next = st_reg;
    if (restart)
    begin
      st_next.left = `DISCARD_RESULTS;
    end
    else if (result_strobe && (st_reg.left != 6'h00))
    begin
      st_next.left = st_reg.left - 6'h01;
    end
    st_next.active = (st_next.left != 6'h00);
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign discard_left   = st_reg.left;
  assign discard_active = st_reg.active;

endmodule // discard_counter

//--- hdl/cal_scaler.sv
// Offset subtraction and full-scale multiplication of filter output
// Assumes samples arrive as 32-bit twos complement on mclk
`timescale 1ns/1ps
`include "adc_bank_defines.svh"

module cal_scaler
  import adc_bank_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic [31:0] sample_in,
  input  wire logic        sample_valid,
  input  wire logic        bypass,
  input  wire logic        suppress,
  input  wire logic [23:0] offset_val,
  input  wire logic [23:0] fullscale_val,
  output logic [31:0]      scaled_out,
  output logic             scaled_valid
);

  scale_s             st_reg;
  scale_s             st_next;
  logic signed [32:0] diff;
  logic signed [57:0] prod;
  logic signed [57:0] shifted;

  always_comb
  begin
    st_next = st_reg;
    diff    = $signed({sample_in[31], sample_in})
            - $signed({offset_val[23], offset_val, 8'h00});
    prod    = diff * $signed({1'b0, fullscale_val});
    shifted = prod >>> `UNITY_SHIFT;
    st_next.valid = sample_valid && !suppress;
    if (sample_valid)
    begin
      if (bypass)
      begin
        st_next.data = sample_in;
      end
      else if (shifted > 58'sh0_0000_007F_FFFF_FF)
      begin
        st_next.data = 32'h7FFF_FFFF;
      end
      else if (shifted < -58'sh0_0000_0080_0000_00)
      begin
        st_next.data = 32'h8000_0000;
      end
      else
      begin
        st_next.data = shifted[31:0];
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign scaled_out   = st_reg.data;
  assign scaled_valid = st_reg.valid;

endmodule // cal_scaler

//--- hdl/adc_config_register_bank.sv
// Configuration and calibration register bank with byte command decoder
// Assumes a serial front end delivering command bytes and read requests
`timescale 1ns/1ps
`include "adc_bank_defines.svh"

// Operation
// - Registers reached only by read/write commands
// - Register write restarts path, 63 results lost
// - Part code fixed in 7:4, 3:0 zero
// - Main bit 7 selects sync behaviour
// - Main bit 6 selects high-resolution mode
// - Bits 5:3 choose output rate, default 010
// - Main bit 2 selects FIR phase
// - Bits 1:0 choose filter path
// - Input bits 6:4 route analog inputs
// - Input bit 3 enables chopping; bit 7 zero
// - Input bits 2:0 select amplifier gain
// - Two bytes hold high-pass corner value
// - Three bytes hold offset correction, reset zero
// - Three bytes hold full-scale correction, top 40h
// - Command pair: start address, then count-1
// - Output minus offset, times full-scale/400000h
module adc_config_register_bank
  import adc_bank_pkg::*;
#(
  parameter logic [3:0] FACTORY_CODE = 4'h5 // Arbitrary value
)
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        serial_reset,
  input  wire logic [7:0]  cmd_byte,
  input  wire logic        cmd_valid,
  input  wire logic        rd_req,
  output logic [7:0]       rd_byte,
  output logic             rd_valid,
  output logic             sync_continuous,
  output logic             high_res_mode,
  output logic [2:0]       output_rate_select,
  output logic             fir_min_phase,
  output logic [1:0]       filter_path_select,
  output logic [2:0]       input_route_select,
  output logic             amp_chopping_enable,
  output logic [2:0]       amp_gain_select,
  output logic [15:0]      highpass_corner_value,
  output logic [23:0]      offset_correction_value,
  output logic [23:0]      fullscale_correction_value,
  output logic             filter_restart,
  output logic             discard_active,
  input  wire logic [31:0] sample_in,
  input  wire logic        sample_valid,
  output logic [31:0]      scaled_out,
  output logic             scaled_valid
);

  bank_s       st_reg;
  bank_s       st_next;
  logic [7:0]  read_value;
  logic [5:0]  discard_left;
  logic        cal_bypass;

  // Register read mux
  always_comb
  begin
    read_value = 8'h00;
    if (st_reg.addr == `ADDR_PART_CODE)
    begin
      read_value = {FACTORY_CODE, 4'h0};
    end
    else if (st_reg.addr <= `ADDR_GAIN_HIGH)
    begin
      read_value = st_reg.regs[st_reg.addr[3:0]];
    end
  end

  // Command decoder
  always_comb
  begin
    st_next          = st_reg;
    st_next.rd_valid = 1'b0;
    st_next.restart  = 1'b0;
    unique case (st_reg.state)
      ST_OPCODE:
      begin
        if (cmd_valid && (cmd_byte[7:5] == `OPCODE_READ))
        begin
          st_next.addr     = cmd_byte[4:0];
          st_next.is_write = 1'b0;
          st_next.state    = ST_COUNT;
        end
        else if (cmd_valid && (cmd_byte[7:5] == `OPCODE_WRITE))
        begin
          st_next.addr     = cmd_byte[4:0];
          st_next.is_write = 1'b1;
          st_next.state    = ST_COUNT;
        end
      end
      ST_COUNT:
      begin
        if (cmd_valid)
        begin
          if (cmd_byte[7:5] == `OPCODE_COUNT)
          begin
            st_next.remain = cmd_byte[4:0];
            st_next.state  = st_reg.is_write ? ST_WRITE : ST_READ;
          end
          else
          begin
            st_next.state = ST_OPCODE;
          end
        end
      end
      ST_READ:
      begin
        if (rd_req)
        begin
          st_next.rd_data  = read_value;
          st_next.rd_valid = 1'b1;
          st_next.addr     = st_reg.addr + 5'h01;
          st_next.remain   = st_reg.remain - 5'h01;
          if (st_reg.remain == 5'h00)
          begin
            st_next.state = ST_OPCODE;
          end
        end
      end
      ST_WRITE:
      begin
        if (cmd_valid)
        begin
          if ((st_reg.addr != `ADDR_PART_CODE) && (st_reg.addr <= `ADDR_GAIN_HIGH))
          begin
            st_next.regs[st_reg.addr[3:0]] = cmd_byte;
          end
          if (st_reg.addr == `ADDR_INPUT_CFG)
          begin
            st_next.regs[2][`RSVD_BIT] = 1'b0;
          end
          st_next.addr   = st_reg.addr + 5'h01;
          st_next.remain = st_reg.remain - 5'h01;
          if (st_reg.remain == 5'h00)
          begin
            st_next.state   = ST_OPCODE;
            st_next.restart = 1'b1;
          end
        end
      end
    endcase
    if (serial_reset)
    begin
      st_next.state = ST_OPCODE;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_reg          <= '0;
      st_reg.state    <= ST_OPCODE;
      st_reg.regs[1]  <= `RST_MAIN_CFG;
      st_reg.regs[2]  <= `RST_INPUT_CFG;
      st_reg.regs[3]  <= `RST_CORNER_LOW;
      st_reg.regs[4]  <= `RST_CORNER_HIGH;
      st_reg.regs[5]  <= `RST_OFFSET_BYTE;
      st_reg.regs[6]  <= `RST_OFFSET_BYTE;
      st_reg.regs[7]  <= `RST_OFFSET_BYTE;
      st_reg.regs[8]  <= `RST_GAIN_LOW;
      st_reg.regs[9]  <= `RST_GAIN_MID;
      st_reg.regs[10] <= `RST_GAIN_HIGH;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Field outputs
  assign sync_continuous     = st_reg.regs[1][`SYNC_BIT];
  assign high_res_mode       = st_reg.regs[1][`MODE_BIT];
  assign output_rate_select  = st_reg.regs[1][`RATE_HI:`RATE_LO];
  assign fir_min_phase       = st_reg.regs[1][`PHASE_BIT];
  assign filter_path_select  = st_reg.regs[1][`FILT_HI:`FILT_LO];
  assign input_route_select  = st_reg.regs[2][`ROUTE_HI:`ROUTE_LO];
  assign amp_chopping_enable = st_reg.regs[2][`AMP_CHOPPING_ENABLE_BIT];
  assign amp_gain_select     = st_reg.regs[2][`GAIN_HI:`GAIN_LO];
  assign highpass_corner_value      = {st_reg.regs[4], st_reg.regs[3]};
  assign offset_correction_value    = {st_reg.regs[7], st_reg.regs[6], st_reg.regs[5]};
  assign fullscale_correction_value = st_reg.regs[10:8];
  assign rd_byte        = st_reg.rd_data;
  assign rd_valid       = st_reg.rd_valid;
  assign filter_restart = st_reg.restart;

  // Calibration skipped unless low-pass stage is in the path
  assign cal_bypass = (st_reg.regs[1][`FILT_HI:`FILT_LO] < `CAL_BYPASS_MIN);

  discard_counter u_discard (
    .mclk           (mclk),
    .sys_rst        (sys_rst),
    .restart        (st_reg.restart),
    .result_strobe  (sample_valid),
    .discard_left   (discard_left),
    .discard_active (discard_active)
  );

  cal_scaler u_scaler (
    .mclk          (mclk),
    .sys_rst       (sys_rst),
    .sample_in     (sample_in),
    .sample_valid  (sample_valid),
    .bypass        (cal_bypass),
    .suppress      (discard_active),
    .offset_val    (offset_correction_value),
    .fullscale_val (fullscale_correction_value),
    .scaled_out    (scaled_out),
    .scaled_valid  (scaled_valid)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  write_restart_a: assert property (
    (st_reg.state == ST_WRITE && cmd_valid && st_reg.remain == 5'h00 && !serial_reset)
    |=> filter_restart ##1 (discard_left == 6'h3F))
    else $error("Write end did not restart path");

  discard_mask_a: assert property (
    discard_active |=> !scaled_valid)
    else $error("Result passed during discard");

  part_code_a: assert property (
    (st_reg.state == ST_READ && rd_req && st_reg.addr == 5'h00)
    |=> rd_valid && (rd_byte == {FACTORY_CODE, 4'h0}))
    else $error("Part code read wrong");

  reserved_zero_a: assert property (
    st_reg.regs[2][7] == 1'b0)
    else $error("Input reserved bit set");

  reset_values_a: assert property (
    $fell(sys_rst) |-> (output_rate_select == 3'h2) && (filter_path_select == 2'h2)
      && high_res_mode && amp_chopping_enable && (fullscale_correction_value == 24'h40_0000))
    else $error("Reset values wrong");

  count_take_a: assert property (
    (st_reg.state == ST_COUNT && cmd_valid && cmd_byte[7:5] == 3'h0 && !serial_reset)
    |=> (st_reg.remain == $past(cmd_byte[4:0])) && (st_reg.state != ST_OPCODE))
    else $error("Count byte not taken");

  addr_step_a: assert property (
    (st_reg.state == ST_WRITE && cmd_valid)
    |=> st_reg.addr == $past(st_reg.addr) + 5'h01)
    else $error("Address did not advance");

  main_write_a: assert property (
    (st_reg.state == ST_WRITE && cmd_valid && st_reg.addr == 5'h01)
    |=> ({sync_continuous, high_res_mode, output_rate_select, fir_min_phase,
          filter_path_select} == $past(cmd_byte)))
    else $error("Main configuration not stored");

  no_stray_write_a: assert property (
    (st_reg.state != ST_WRITE) |=> $stable(highpass_corner_value))
    else $error("Register changed outside write");

  count_abort_a: assert property (
    (st_reg.state == ST_COUNT && cmd_valid && cmd_byte[7:5] != 3'h0)
    |=> (st_reg.state == ST_OPCODE))
    else $error("Bad count byte kept frame");

  frame_abort_a: assert property (
    serial_reset |=> (st_reg.state == ST_OPCODE))
    else $error("Serial reset kept frame");

  rd_answer_a: assert property (
    !(st_reg.state == ST_READ && rd_req) |=> !rd_valid)
    else $error("Read data without request");

  restart_cause_a: assert property (
    filter_restart |-> ($past(st_reg.state) == ST_WRITE) && $past(cmd_valid)
      && ($past(st_reg.remain) == 5'h00))
    else $error("Restart without write end");

  discard_step_a: assert property (
    (discard_active && sample_valid && !st_reg.restart)
    |=> (discard_left == $past(discard_left) - 6'h01))
    else $error("Discard count did not step");

  scale_answer_a: assert property (
    (sample_valid && !discard_active) |=> scaled_valid)
    else $error("Result not delivered");

  input_write_a: assert property (
    (st_reg.state == ST_WRITE && cmd_valid && st_reg.addr == 5'h02)
    |=> ({input_route_select, amp_chopping_enable, amp_gain_select} == $past(cmd_byte[6:0])))
    else $error("Input configuration not stored");

  corner_write_a: assert property (
    (st_reg.state == ST_WRITE && cmd_valid && st_reg.addr == 5'h04)
    |=> (highpass_corner_value[15:8] == $past(cmd_byte)))
    else $error("Corner high byte not stored");

endmodule // adc_config_register_bank

//--- verif/host_model.sv
// Host side model: frames serial register commands byte by byte
// Assumes the bank samples cmd_valid and rd_req on rising mclk
`timescale 1ns/1ps

module host_model
(
  input  wire logic       mclk,
  output logic [7:0]      cmd_byte,
  output logic            cmd_valid,
  output logic            rd_req,
  input  wire logic [7:0] rd_byte,
  input  wire logic       rd_valid
);
  localparam int GAP = 24;

  initial
  begin
    cmd_byte  = 8'hA5;
    cmd_valid = 1'b0;
    rd_req    = 1'b0;
  end

  // One byte, then the idle gap; idle bus shows the inverse
  task automatic send_byte(input logic [7:0] b);
    @(posedge mclk);
    cmd_byte  <= b;
    cmd_valid <= 1'b1;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    cmd_byte  <= ~b;
    repeat (GAP) @(posedge mclk);
  endtask

  // Opcode with start address, then count minus one
  task automatic send_cmd(input logic [2:0] op, input logic [4:0] a, input int n);
    send_byte({op, a});
    send_byte({3'h0, 5'(n - 1)});
  endtask

  task automatic read_byte(output logic [7:0] d, output logic ok);
    @(posedge mclk);
    rd_req <= 1'b1;
    @(posedge mclk);
    rd_req <= 1'b0;
    ok = 1'b0;
    d  = 8'hXX;
    repeat (3)
    begin
      @(posedge mclk);
      if (!ok && rd_valid === 1'b1)
      begin
        ok = 1'b1;
        d  = rd_byte;
      end
    end
    repeat (GAP) @(posedge mclk);
  endtask
endmodule // host_model

//--- verif/tb_adc_config_register_bank.sv
// Self-checking bench for the converter register bank
// Assumes the host model drives the command port
`timescale 1ns/1ps

module tb_adc_config_register_bank;
  import adc_bank_pkg::*;
  localparam logic [3:0] FCODE = 4'hA; // Arbitrary value

  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        serial_reset = 1'b0;
  logic [7:0]  cmd_byte, rd_byte;
  logic        cmd_valid, rd_req, rd_valid;
  logic        sync_continuous, high_res_mode, fir_min_phase, amp_chopping_enable;
  logic [2:0]  output_rate_select, input_route_select, amp_gain_select;
  logic [1:0]  filter_path_select;
  logic [15:0] highpass_corner_value;
  logic [23:0] offset_correction_value, fullscale_correction_value;
  logic        filter_restart, discard_active, sample_valid = 1'b0, scaled_valid;
  logic [31:0] sample_in = 32'h0, scaled_out, last_scaled;
  logic [7:0]  exp_regs [0:31];
  logic [7:0]  wdat [0:31];
  int          num_errors = 0, compares = 0, restarts = 0, nwr = 0, nsv = 0;
  int          seed = 32'hb67caf10;

  always #4 mclk = ~mclk;

  host_model host_u (.mclk(mclk), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid),
    .rd_req(rd_req), .rd_byte(rd_byte), .rd_valid(rd_valid));

  adc_config_register_bank #(.FACTORY_CODE(FCODE)) dut_u (.mclk(mclk), .sys_rst(sys_rst),
    .serial_reset(serial_reset), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid), .rd_req(rd_req),
    .rd_byte(rd_byte), .rd_valid(rd_valid), .sync_continuous(sync_continuous),
    .high_res_mode(high_res_mode), .output_rate_select(output_rate_select),
    .fir_min_phase(fir_min_phase), .filter_path_select(filter_path_select),
    .input_route_select(input_route_select), .amp_chopping_enable(amp_chopping_enable),
    .amp_gain_select(amp_gain_select), .highpass_corner_value(highpass_corner_value),
    .offset_correction_value(offset_correction_value),
    .fullscale_correction_value(fullscale_correction_value),
    .filter_restart(filter_restart), .discard_active(discard_active),
    .sample_in(sample_in), .sample_valid(sample_valid),
    .scaled_out(scaled_out), .scaled_valid(scaled_valid));

  always @(posedge mclk)
  begin
    if (filter_restart === 1'b1) restarts <= restarts + 1;
    if (scaled_valid === 1'b1)
    begin
      nsv <= nsv + 1;
      last_scaled <= scaled_out;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  function automatic logic [23:0] w24(input int a);
    return {exp_regs[a + 2], exp_regs[a + 1], exp_regs[a]};
  endfunction

  task automatic init_exp();
    foreach (exp_regs[i]) exp_regs[i] = 8'h00;
    exp_regs[0] = {FCODE, 4'h0};
    {exp_regs[1], exp_regs[2], exp_regs[3], exp_regs[4]} = 32'h52083203;
    exp_regs[10] = 8'h40;
  endtask

  function automatic logic [31:0] exp_scale(input logic [31:0] s);
    longint p;
    p = longint'($signed(s)) - longint'($signed({w24(5), 8'h00}));
    p = (p * longint'(w24(8))) >>> 22;
    if (exp_regs[1][1:0] < 2'h2) return s;
    if (p > 64'sh7FFFFFFF) return 32'h7FFFFFFF;
    if (p < -64'sh80000000) return 32'h80000000;
    return p[31:0];
  endfunction

  task automatic wr_block(input logic [4:0] a, input int n);
    logic [4:0] x;
    host_u.send_cmd(3'h2, a, n);
    for (int i = 0; i < n; i++)
    begin
      x = a + 5'(i);
      host_u.send_byte(wdat[i]);
      if (x != 5'h0 && x <= 5'hA) exp_regs[x] = (x == 5'h2) ? (wdat[i] & 8'h7F) : wdat[i];
    end
    nwr++;
  endtask

  task automatic rd_block(input logic [4:0] a, input int n);
    logic [7:0] d;
    logic       ok;
    host_u.send_cmd(3'h1, a, n);
    for (int i = 0; i < n; i++)
    begin
      host_u.read_byte(d, ok);
      chk(ok, 1'b1, "read answer");
      chk(d, exp_regs[5'(a + 5'(i))], "read byte");
    end
  endtask

  task automatic chk_outs();
    chk(sync_continuous, exp_regs[1][7], "sync");
    chk(high_res_mode, exp_regs[1][6], "mode");
    chk(output_rate_select, exp_regs[1][5:3], "rate");
    chk(fir_min_phase, exp_regs[1][2], "phase");
    chk(filter_path_select, exp_regs[1][1:0], "filter");
    chk(input_route_select, exp_regs[2][6:4], "route");
    chk(amp_chopping_enable, exp_regs[2][3], "amp_chopping_enable");
    chk(amp_gain_select, exp_regs[2][2:0], "gain");
    chk(highpass_corner_value, {exp_regs[4], exp_regs[3]}, "corner");
    chk(offset_correction_value, w24(5), "offset");
    chk(fullscale_correction_value, w24(8), "full scale");
  endtask

  task automatic sample(input logic [31:0] v);
    @(posedge mclk);
    sample_in    <= v;
    sample_valid <= 1'b1;
    @(posedge mclk);
    sample_valid <= 1'b0;
    sample_in    <= ~v;
  endtask

  initial
  begin
    #200000;
    num_errors++;
    results();
  end

  initial
  begin
    int k;
    logic [31:0] v;
    init_exp();
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    chk_outs();
    chk(discard_active, 1'b0, "discard idle");
    rd_block(5'h0, 11);
    $display("test reset values done");
    wdat[0] = {~FCODE, 4'h0};
    wdat[1] = 8'($random(seed));
    wr_block(5'h0, 2);
    rd_block(5'h0, 2);
    rd_block(5'h9, 4);
    $display("test read-only and range done");
    for (int i = 0; i < 8; i++)
    begin
      wdat[0] = {i[0], i[1], 3'(i % 5), i[2], i[1:0]};
      wdat[1] = {1'b0, 3'(i % 5), i[0], 3'(i % 7)};
      wr_block(5'h1, 2);
      chk_outs();
    end
    $display("test field codes done");
    for (int i = 0; i < 10; i++) wdat[i] = 8'($random(seed));
    wdat[1][7] = 1'b0;
    wdat[0][1] = 1'b1; // Keep calibration in the path
    wr_block(5'h1, 10);
    chk_outs();
    rd_block(5'h1, 10);
    chk(restarts, nwr, "restart pulses");
    chk(discard_active, 1'b1, "discard start");
    k = nsv;
    repeat (63) sample($random(seed));
    repeat (2) @(posedge mclk);
    #1;
    chk(nsv, k, "results lost");
    chk(discard_active, 1'b0, "discard end");
    $display("test restart discard done");
    for (int i = 0; i < 3; i++)
    begin
      v = (i == 0) ? 32'h00001000 : $random(seed);
      sample(v);
      repeat (2) @(posedge mclk);
      #1;
      chk(nsv, k + i + 1, "scaled count");
      chk(last_scaled, exp_scale(v), "scaled value");
    end
    $display("test calibration done");
    wdat[0] = 8'h51;
    wr_block(5'h1, 1);
    repeat (63) sample($random(seed));
    v = $random(seed);
    sample(v);
    repeat (2) @(posedge mclk);
    #1;
    chk(last_scaled, v, "bypass value");
    $display("test calibration bypass done");
    // Bad count byte, stray byte, then a frame cut by serial reset
    k = restarts;
    host_u.send_byte(8'h45);
    host_u.send_byte(8'h20);
    host_u.send_byte(8'h9A);
    host_u.send_cmd(3'h2, 5'h5, 1);
    @(posedge mclk);
    serial_reset <= 1'b1;
    @(posedge mclk);
    serial_reset <= 1'b0;
    host_u.send_byte(8'h77);
    #1;
    chk(restarts, k, "aborted frames");
    chk_outs();
    $display("test aborted frames done");
    wr_block(5'h5, 6);
    #1;
    chk(discard_active, 1'b1, "discard before reset");
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    init_exp();
    #1;
    chk_outs();
    chk(discard_active, 1'b0, "discard after reset");
    $display("test mid-run reset done");
    results();
  end
endmodule // tb_adc_config_register_bank
